// File: core/class_d_pkg.sv
package class_d_pkg;

	// core clock and data-loss timing
	localparam int CLK_FREQ_KHZ = 100_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOSS_TIME_MS = 50;
	localparam int LOSS_CYCLES = LOSS_TIME_MS * CLK_FREQ_KHZ;
	// assumed external state-machine clock rate, override per board
	localparam int EXT_CLK_KHZ = 1_000;
	localparam int LOSS_EXT_TICKS = LOSS_TIME_MS * EXT_CLK_KHZ;

	// nonoverlap unit: one step of the code, rounded up to whole cycles
	localparam int NOL_UNIT_NS = 25;
	localparam int NOL_UNIT_CYC = (NOL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NOL_CNT_W = 8;

	// transistor pairs and strap code widths
	localparam int PAIRS = 4;
	localparam int STEP_W = 4;
	localparam logic [STEP_W-1:0] STEP_ONE = 4'h1;

	// positions inside the synchronised pin vector
	localparam int SY_RPD = 0;
	localparam int SY_MUTE = 1;
	localparam int SY_A = 2;
	localparam int SY_B = 3;
	localparam int SY_C = 4;
	localparam int SY_D = 5;
	localparam int SY_EXT = 6;
	localparam int SY_CSRC = 7;
	localparam int SY_CHAN = 8;
	localparam int SY_TWARN = 9;
	localparam int SY_TSD = 10;
	localparam int SY_TCOOL = 11;
	localparam int SY_OC = 12;
	localparam int SY_FP = 13;
	localparam int SYNC_W = 17;
	// fault pins idle high through their pull-ups, mute idles high, all else low
	localparam logic [SYNC_W-1:0] SYNC_RST = 17'h1e002;

	// thermal protection states
	typedef enum logic [1:0] {
		THERM_OK,
		THERM_WARN,
		THERM_SHUTDOWN
	} thermal_state_t;

endpackage

// File: core/gate_drive_if.sv
interface gate_drive_if;
	logic [class_d_pkg::PAIRS-1:0] level; // wanted half-bridge level per pair
	logic [class_d_pkg::PAIRS-1:0] hi_en; // high side allowed
	logic [class_d_pkg::PAIRS-1:0] lo_en; // low side allowed
	logic kill; // all transistors off
	logic [class_d_pkg::STEP_W-1:0] nol_step; // nonoverlap step 1..8
	logic [class_d_pkg::PAIRS-1:0] gate_hi; // registered high-side drive
	logic [class_d_pkg::PAIRS-1:0] gate_lo; // registered low-side drive

	modport ctrl (
		output level,
		output hi_en,
		output lo_en,
		output kill,
		output nol_step,
		input gate_hi,
		input gate_lo
	);

	modport drv (
		input level,
		input hi_en,
		input lo_en,
		input kill,
		input nol_step,
		output gate_hi,
		output gate_lo
	);
endinterface

// File: core/dead_time_gen.sv
module dead_time_gen (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	gate_drive_if.drv gd
);

	// one dead-time slice per transistor pair
	genvar p;
	generate
		for (p = 0; p < class_d_pkg::PAIRS; p++) begin : g_pair
			logic applied; // level the pair is switching toward
			logic [class_d_pkg::NOL_CNT_W-1:0] dead_cnt; // remaining dead cycles
			logic changing; // wanted level differs from applied one

			assign changing = gd.level[p] != applied;

			// a level change reloads the dead time before the new side turns on
			always_ff @(posedge core_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					applied <= 1'b0;
					dead_cnt <= '0;
				end else if (changing) begin
					applied <= gd.level[p];
					dead_cnt <= class_d_pkg::NOL_CNT_W'(int'(gd.nol_step) * class_d_pkg::NOL_UNIT_CYC);
				end else if (dead_cnt != '0) begin
					dead_cnt <= dead_cnt - 1'b1;
				end
			end

			// gates are exclusive by the applied level, and both off while counting
			always_ff @(posedge core_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					gd.gate_hi[p] <= 1'b0;
					gd.gate_lo[p] <= 1'b0;
				end else begin
					gd.gate_hi[p] <= !gd.kill && !changing && dead_cnt == '0 && applied
						&& gd.hi_en[p];
					gd.gate_lo[p] <= !gd.kill && !changing && dead_cnt == '0 && !applied
						&& gd.lo_en[p];
				end
			end
		end
	endgenerate

endmodule

// File: core/class_d_stage_ctrl.sv
// Summary of operation
// - latch clock and channel straps at reset release
// - clock strap low internal, high external clock
// - dead time between pair transistors on change
// - mute input low mutes the outputs
// - two-channel: A drives A/B, C drives C/D
// - two-channel: fault pin 0 flags 50 ms silence
// - four-channel: no data-loss detection
// - four-channel: fault pin 0 low disables low sides
// - four-channel: each input drives its own output
// - above 135 degrees assert thermal warning pin 2
// - above 150 degrees assert shutdown pin 3, stop
// - below 120 degrees clear both, resume
// - overcurrent mutes and asserts fault pin 1
// - overcurrent latched until reset or mute cycle
// - edge speed from pins 3, 2, B at release
// - edge step is {p3,p2,~B} plus one
// - nonoverlap from pins 1, 0, D at release
// - nonoverlap step is {p1,p0,~D} plus one
// - fault pins driven outside reset (pin 0 not in four-channel), released during
module class_d_stage_ctrl #(
	parameter int LOSS_TICKS_INT = class_d_pkg::LOSS_CYCLES, // internal-clock timeout
	parameter int LOSS_TICKS_EXT = class_d_pkg::LOSS_EXT_TICKS // external-clock timeout
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic reset_powerdown_n_i,
	input wire logic mute_n_i,
	input wire logic switch_in_a_i,
	input wire logic switch_in_b_i,
	input wire logic switch_in_c_i,
	input wire logic switch_in_d_i,
	input wire logic ext_clk_i,
	input wire logic clock_source_strap_i,
	input wire logic channel_config_strap_i,
	input wire logic temp_above_warn_i,
	input wire logic temp_above_shutdown_i,
	input wire logic temp_below_recover_i,
	input wire logic overcurrent_i,
	input wire logic [3:0] fault_pin_i,
	output logic [3:0] fault_pin_o,
	output logic [3:0] fault_pin_oe_o,
	output logic [class_d_pkg::PAIRS-1:0] gate_hi_o,
	output logic [class_d_pkg::PAIRS-1:0] gate_lo_o,
	output logic [class_d_pkg::STEP_W-1:0] edge_speed_o,
	output logic [class_d_pkg::STEP_W-1:0] nonoverlap_o
);

	localparam int LOSS_MAX = (LOSS_TICKS_INT > LOSS_TICKS_EXT) ? LOSS_TICKS_INT : LOSS_TICKS_EXT;
	localparam int LOSS_W = $clog2(LOSS_MAX + 1);

	logic [class_d_pkg::SYNC_W-1:0] pin_meta; // first synchroniser stage
	logic [class_d_pkg::SYNC_W-1:0] pin_sync; // second synchroniser stage
	logic [class_d_pkg::SYNC_W-1:0] pin_raw; // packed asynchronous pins
	logic in_reset; // reset/power-down pin held low
	logic clk_src; // captured clock-source strap
	logic four_ch; // captured channel-configuration strap
	logic mute_prev; // last synchronised mute level
	logic ext_prev; // last synchronised external clock level
	logic sm_tick; // one tick of the selected state-machine clock
	logic a_prev; // last synchronised input A
	logic c_prev; // last synchronised input C
	logic [LOSS_W-1:0] loss_cnt; // ticks since the last A or C edge
	logic [LOSS_W-1:0] loss_limit; // timeout for the selected clock
	logic data_lost; // no A or C edge for the timeout
	logic oc_latched; // overcurrent mute held
	class_d_pkg::thermal_state_t therm; // thermal protection state
	class_d_pkg::thermal_state_t next_therm; // next thermal state
	logic [class_d_pkg::PAIRS-1:0] next_level; // wanted pair levels
	logic low_side_en; // four-channel low-side enable

	gate_drive_if gd ();

	// pack every asynchronous pin for the two-stage synchroniser
	assign pin_raw = {fault_pin_i, overcurrent_i, temp_below_recover_i, temp_above_shutdown_i,
		temp_above_warn_i, channel_config_strap_i, clock_source_strap_i, ext_clk_i,
		switch_in_d_i, switch_in_c_i, switch_in_b_i, switch_in_a_i, mute_n_i,
		reset_powerdown_n_i};

	// two flip-flops ahead of any logic for every pin
	// the reset value matches each pin's idle level, so no edge is seen at release
	// only the second stage is read by logic; the first may go metastable
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta <= class_d_pkg::SYNC_RST;
			pin_sync <= class_d_pkg::SYNC_RST;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	assign in_reset = !pin_sync[class_d_pkg::SY_RPD];

	// straps track the pins while held in reset and freeze at release
	// the board must hold them steady a few cycles past the release
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_src <= 1'b0;
			four_ch <= 1'b0;
		end else if (in_reset) begin
			clk_src <= pin_sync[class_d_pkg::SY_CSRC];
			four_ch <= pin_sync[class_d_pkg::SY_CHAN];
		end
	end

	// edge speed code: pins 3 and 2 with inverted B, offset by one
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			edge_speed_o <= class_d_pkg::STEP_ONE;
		end else if (in_reset) begin
			// follows the pins while held, so the last sample before release stays
			edge_speed_o <= {1'b0, pin_sync[class_d_pkg::SY_FP + 3], pin_sync[class_d_pkg::SY_FP + 2],
				!pin_sync[class_d_pkg::SY_B]} + class_d_pkg::STEP_ONE;
		end
	end

	// nonoverlap code: pins 1 and 0 with inverted D, offset by one
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nonoverlap_o <= class_d_pkg::STEP_ONE;
		end else if (in_reset) begin
			// the dead-time generator reads this value directly
			nonoverlap_o <= {1'b0, pin_sync[class_d_pkg::SY_FP + 1], pin_sync[class_d_pkg::SY_FP],
				!pin_sync[class_d_pkg::SY_D]} + class_d_pkg::STEP_ONE;
		end
	end

	// control pin history: mute idles high, so its history resets high
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mute_prev <= 1'b1;
			ext_prev <= 1'b0;
		end else begin
			mute_prev <= pin_sync[class_d_pkg::SY_MUTE];
			ext_prev <= pin_sync[class_d_pkg::SY_EXT];
		end
	end

	// switching input history for the data-loss restart
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			a_prev <= 1'b0;
			c_prev <= 1'b0;
		end else begin
			a_prev <= pin_sync[class_d_pkg::SY_A];
			c_prev <= pin_sync[class_d_pkg::SY_C];
		end
	end

	// internal clock ticks every cycle, external on each rising edge
	// the external clock is sampled as data, so it must run well below the core clock
	// a stopped external clock stops the timer, which then never flags a loss
	assign sm_tick = clk_src ? (pin_sync[class_d_pkg::SY_EXT] && !ext_prev) : 1'b1;
	assign loss_limit = clk_src ? LOSS_W'(LOSS_TICKS_EXT) : LOSS_W'(LOSS_TICKS_INT);

	// data-loss timer: restarts on A or C edges, saturates at the limit
	// saturation keeps the flag up for as long as the silence lasts
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loss_cnt <= '0;
		end else if (in_reset || four_ch) begin
			// four-channel mode never watches for silence
			loss_cnt <= '0;
		end else if (pin_sync[class_d_pkg::SY_A] != a_prev
			|| pin_sync[class_d_pkg::SY_C] != c_prev) begin
			loss_cnt <= '0;
		end else if (sm_tick && loss_cnt != loss_limit) begin
			loss_cnt <= loss_cnt + 1'b1;
		end
	end

	// loss is flagged once the count reaches the limit
	assign data_lost = loss_cnt == loss_limit;

	// thermal hysteresis: shutdown beats warning and recovery
	// the three comparators are separate, so a gap between them holds the state
	// the warning stays asserted through shutdown until the die cools
	always_comb begin
		next_therm = therm;
		unique case (therm)
			class_d_pkg::THERM_OK: begin
				if (pin_sync[class_d_pkg::SY_TSD]) begin
					next_therm = class_d_pkg::THERM_SHUTDOWN;
				end else if (pin_sync[class_d_pkg::SY_TWARN]) begin
					next_therm = class_d_pkg::THERM_WARN;
				end
			end
			class_d_pkg::THERM_WARN: begin
				if (pin_sync[class_d_pkg::SY_TSD]) begin
					next_therm = class_d_pkg::THERM_SHUTDOWN;
				end else if (pin_sync[class_d_pkg::SY_TCOOL]) begin
					next_therm = class_d_pkg::THERM_OK;
				end
			end
			class_d_pkg::THERM_SHUTDOWN: begin
				// only cooling below the recovery point leaves shutdown
				if (pin_sync[class_d_pkg::SY_TCOOL] && !pin_sync[class_d_pkg::SY_TSD]) begin
					next_therm = class_d_pkg::THERM_OK;
				end
			end
			default: begin
				next_therm = class_d_pkg::THERM_SHUTDOWN;
			end
		endcase
	end

	// thermal state register
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			therm <= class_d_pkg::THERM_OK;
		end else begin
			therm <= next_therm;
		end
	end

	// overcurrent latch: set wins, cleared by reset or mute release
	// a persisting short keeps it set even through a mute cycle
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			oc_latched <= 1'b0;
		end else if (pin_sync[class_d_pkg::SY_OC]) begin
			oc_latched <= 1'b1;
		end else if (in_reset) begin
			oc_latched <= 1'b0;
		end else if (pin_sync[class_d_pkg::SY_MUTE] && !mute_prev) begin
			// mute deassert can only follow a mute assert
			oc_latched <= 1'b0;
		end
	end

	// wanted pair levels from the channel mode
	always_comb begin
		if (four_ch) begin
			next_level = {pin_sync[class_d_pkg::SY_D], pin_sync[class_d_pkg::SY_C],
				pin_sync[class_d_pkg::SY_B], pin_sync[class_d_pkg::SY_A]};
		end else begin
			// bridge: the second half of each pair is the inverse
			next_level = {!pin_sync[class_d_pkg::SY_C], pin_sync[class_d_pkg::SY_C],
				!pin_sync[class_d_pkg::SY_A], pin_sync[class_d_pkg::SY_A]};
		end
	end

	// fault pin 0 is a low-side enable input only in four-channel mode
	assign low_side_en = !four_ch || pin_sync[class_d_pkg::SY_FP];

	// requests to the dead-time generator
	// kill gathers every cause that must hold all transistors off
	// high sides have no disable of their own
	assign gd.level = next_level;
	assign gd.hi_en = '1;
	assign gd.lo_en = {class_d_pkg::PAIRS{low_side_en}};
	assign gd.kill = in_reset || !pin_sync[class_d_pkg::SY_MUTE] || oc_latched
		|| therm == class_d_pkg::THERM_SHUTDOWN;
	assign gd.nol_step = nonoverlap_o;

	// per-pair dead time and the registered gate drive
	dead_time_gen u_dead_time (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.gd(gd.drv)
	);

	assign gate_hi_o = gd.gate_hi;
	assign gate_lo_o = gd.gate_lo;

	// fault pin values: active-low flags once out of device reset
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_pin_o <= 4'hf;
		end else if (in_reset) begin
			// released pins read high through their pull-ups
			fault_pin_o <= 4'hf;
		end else begin
			fault_pin_o[3] <= therm != class_d_pkg::THERM_SHUTDOWN;
			fault_pin_o[2] <= therm == class_d_pkg::THERM_OK;
			fault_pin_o[1] <= !oc_latched;
			fault_pin_o[0] <= !data_lost;
		end
	end

	// fault pin directions: all released in reset so straps can be read
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_pin_oe_o <= 4'h0;
		end else if (in_reset) begin
			fault_pin_oe_o <= 4'h0;
		end else begin
			// pin 0 stays an input in four-channel mode
			fault_pin_oe_o <= {3'h7, !four_ch};
		end
	end

endmodule

// File: testbench/class_d_stage_ctrl_properties.sv
module class_d_ctrl_props (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic reset_powerdown_n_i,
	input wire logic mute_n_i,
	input wire logic channel_config_strap_i,
	input wire logic temp_above_shutdown_i,
	input wire logic overcurrent_i,
	input wire logic [3:0] fault_pin_o,
	input wire logic [3:0] fault_pin_oe_o,
	input wire logic [class_d_pkg::PAIRS-1:0] gate_hi_o,
	input wire logic [class_d_pkg::PAIRS-1:0] gate_lo_o,
	input wire logic [class_d_pkg::STEP_W-1:0] edge_speed_o,
	input wire logic [class_d_pkg::STEP_W-1:0] nonoverlap_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// both sides of a pair never conduct together
	property p_no_shoot; (gate_hi_o & gate_lo_o) == 4'h0; endproperty
	a_no_shoot: assert property (p_no_shoot) else $error("pair overlap");
	// a held mute stops every transistor
	property p_mute; !mute_n_i [*5] |-> (gate_hi_o | gate_lo_o) == 4'h0; endproperty
	a_mute: assert property (p_mute) else $error("gates on while muted");
	// shutdown flag and power stage off while hot
	property p_tsd; (reset_powerdown_n_i && temp_above_shutdown_i) [*6]
		|-> !fault_pin_o[3] && (gate_hi_o | gate_lo_o) == 4'h0; endproperty
	a_tsd: assert property (p_tsd) else $error("shutdown not applied");
	property p_oc; (reset_powerdown_n_i && overcurrent_i) [*6] |-> !fault_pin_o[1]; endproperty
	a_oc: assert property (p_oc) else $error("overcurrent not flagged");
	// latched overcurrent survives without a mute cycle
	property p_oc_hold; (mute_n_i && reset_powerdown_n_i) [*6] ##0 !fault_pin_o[1]
		|=> !fault_pin_o[1]; endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("overcurrent cleared alone");
	// fault pins released and gates off in device reset
	property p_oe_rst; !reset_powerdown_n_i [*5] |-> fault_pin_oe_o == 4'h0
		&& fault_pin_o == 4'hf && (gate_hi_o | gate_lo_o) == 4'h0; endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("pins driven in reset");
	// pin 0 becomes an input in four-channel mode
	property p_oe_run; reset_powerdown_n_i [*6]
		|-> fault_pin_oe_o == (channel_config_strap_i ? 4'he : 4'hf); endproperty
	a_oe_run: assert property (p_oe_run) else $error("wrong pin direction");
	property p_codes; reset_powerdown_n_i [*8]
		|-> $stable(edge_speed_o) && $stable(nonoverlap_o); endproperty
	a_codes: assert property (p_codes) else $error("codes moved");
	c_loss: cover property (fault_pin_oe_o[0] && !fault_pin_o[0]);
	c_tsd: cover property (fault_pin_oe_o[3] && !fault_pin_o[3]);
	c_four: cover property (fault_pin_oe_o == 4'he && gate_hi_o == 4'ha);
endmodule

bind class_d_stage_ctrl class_d_ctrl_props chk_u (.core_clk_i, .nrst_i,
	.reset_powerdown_n_i, .mute_n_i, .channel_config_strap_i, .temp_above_shutdown_i,
	.overcurrent_i, .fault_pin_o, .fault_pin_oe_o, .gate_hi_o, .gate_lo_o,
	.edge_speed_o, .nonoverlap_o);

// File: testbench/pwm_source_model.sv
module pwm_source_model (
	input wire logic core_clk_i,
	input wire logic [3:0] set_val_i, // levels held while nothing toggles
	input wire logic [3:0] toggle_i, // lines that switch, zero stops the modulator
	input wire logic [3:0] per_i, // cycles between switching edges
	output logic [3:0] switch_o // switching inputs a..d
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0; // edge spacing counter
	initial switch_o = 4'h0;
	// holds strap levels when stopped, otherwise toggles the chosen lines
	always @(negedge core_clk_i) begin
		cnt <= (cnt + 4'h1 >= per_i) ? 4'h0 : cnt + 4'h1;
		if (toggle_i == 4'h0) begin
			switch_o <= set_val_i;
		end else if (cnt == 4'h0) begin
			switch_o <= switch_o ^ toggle_i;
		end
	end
endmodule

// File: testbench/class_d_stage_ctrl_tb.sv
module class_d_stage_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [2:0] p; logic [3:0] s;} strap_row_t;
	// strap pin levels beside the step they should select
	strap_row_t rows [8] = '{'{3'b001, 4'h1}, '{3'b000, 4'h2}, '{3'b011, 4'h3},
		'{3'b010, 4'h4}, '{3'b101, 4'h5}, '{3'b100, 4'h6}, '{3'b111, 4'h7}, '{3'b110, 4'h8}};
	logic core_clk_i = 0, nrst_i = 0, rpd = 0, mute = 1, cfg = 0, csrc = 0, ext = 0;
	logic ext_run = 0, warn = 0, shut = 0, cool = 0, oc = 0;
	logic [3:0] pull_low = 0, sval = 0, tog = 0, sw, fp_i, fp_o, fp_oe, g_hi, g_lo, es, nl;
	int fail_count = 0, n_checks = 0;
	// wire level: driven value, else internal pull-up against the board resistor
	assign fp_i = (fp_oe & fp_o) | (~fp_oe & ~pull_low);
	initial forever #5 core_clk_i = ~core_clk_i;
	// external state-machine clock, unrelated in phase
	always #37.3 if (ext_run) ext = ~ext;
	pwm_source_model src_u (.core_clk_i(core_clk_i), .set_val_i(sval), .toggle_i(tog),
		.per_i(4'h2), .switch_o(sw));
	class_d_stage_ctrl #(.LOSS_TICKS_INT(40), .LOSS_TICKS_EXT(10)) dut_u (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reset_powerdown_n_i(rpd),
		.mute_n_i(mute), .switch_in_a_i(sw[0]), .switch_in_b_i(sw[1]),
		.switch_in_c_i(sw[2]), .switch_in_d_i(sw[3]), .ext_clk_i(ext),
		.clock_source_strap_i(csrc), .channel_config_strap_i(cfg),
		.temp_above_warn_i(warn), .temp_above_shutdown_i(shut),
		.temp_below_recover_i(cool), .overcurrent_i(oc), .fault_pin_i(fp_i),
		.fault_pin_o(fp_o), .fault_pin_oe_o(fp_oe), .gate_hi_o(g_hi), .gate_lo_o(g_lo),
		.edge_speed_o(es), .nonoverlap_o(nl));
	task automatic w(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// device reset cycle with straps set while the pin is low
	task automatic dev_rst(input logic cf, input logic cs, input logic [3:0] pl,
		input logic [3:0] sv);
		rpd = 0;
		cfg = cf;
		csrc = cs;
		pull_low = pl;
		sval = sv;
		tog = 4'h0;
		w(6);
		rpd = 1;
		w(6);
		pull_low = 4'h0;
		w(4);
	endtask
	initial begin
		w(6);
		nrst_i = 1;
		for (int i = 0; i < 8; i++) begin
			dev_rst(0, 0, ~{rows[i].p[2:1], rows[7-i].p[2:1]},
				{rows[7-i].p[0], 1'b0, rows[i].p[0], 1'b0});
			chk(es, rows[i].s);
			chk(nl, rows[7-i].s);
		end
		// two-channel bridge, B and D changes ignored
		sval = 4'b1011;
		w(40);
		chk(g_hi, 4'h9);
		chk(g_lo, 4'h6);
		sval = 4'b0001;
		w(40);
		chk(g_hi, 4'h9);
		// data loss when A and C go quiet
		tog = 4'h5;
		w(100);
		chk(fp_i, 4'hf);
		tog = 4'h0;
		w(80);
		chk(fp_i, 4'he);
		tog = 4'h5;
		w(20);
		chk(fp_i, 4'hf);
		// thermal warning, shutdown, hysteresis, recovery
		warn = 1;
		w(8);
		chk(fp_i, 4'hb);
		shut = 1;
		w(8);
		chk(fp_i, 4'h3);
		chk(g_hi | g_lo, 4'h0);
		warn = 0;
		shut = 0;
		w(20);
		chk(fp_i, 4'h3);
		cool = 1;
		w(8);
		chk(fp_i, 4'hf);
		cool = 0;
		// overcurrent latch held until a mute cycle clears it
		oc = 1;
		w(8);
		chk(fp_i, 4'hd);
		oc = 0;
		w(30);
		chk(fp_i, 4'hd);
		chk(g_hi | g_lo, 4'h0);
		mute = 0;
		w(8);
		mute = 1;
		w(40);
		chk(fp_i, 4'hf);
		// four-channel: one input per output, pin 0 disables low sides
		dev_rst(1, 0, 4'h0, 4'b1010);
		chk(es, 4'h7);
		w(60);
		chk(g_hi, 4'ha);
		chk(g_lo, 4'h5);
		pull_low = 4'h1;
		w(10);
		chk(g_lo, 4'h0);
		chk(g_hi, 4'ha);
		w(80);
		chk(fp_oe, 4'he);
		pull_low = 4'h0;
		// external clock: no ticks while it stands still
		dev_rst(0, 1, 4'h0, 4'h0);
		w(80);
		chk(fp_i, 4'hf);
		ext_run = 1;
		w(150);
		chk(fp_i, 4'he);
		conclude();
	end
	// cuts a hang short
	initial begin
		repeat (6000) @(posedge core_clk_i);
		fail_count++;
		conclude();
	end
endmodule
